// *** pkg/dlt_pkg.sv ***
// die link target: shared constants, types and helpers
// assumes: compiled before every file under hw/
package dlt_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int DLT_DATA_W   = 8;
	localparam int DLT_WORD_W   = 16;
	localparam int DLT_SPACE_B  = 256;
	localparam int DLT_ADDR_W   = $clog2(DLT_SPACE_B);
	localparam int DLT_ADDR_LSB = 0;

	// ------------------------------------------------------------
	// link bytes
	// ------------------------------------------------------------
	localparam logic [DLT_DATA_W-1:0] DLT_IDLE_BYTE = 8'h00;
	localparam logic [3:0]            DLT_OP_WRITE  = 4'h1;
	localparam logic [3:0]            DLT_OP_READ   = 4'h2;
	localparam logic [3:0]            DLT_OP_WAKE   = 4'h5;
	localparam logic [1:0]            DLT_RSVD_ZERO = 2'h0;

	typedef struct packed {
		logic [1:0] rsvd;
		logic       word;
		logic       nb;
		logic [3:0] op;
	} dlt_cmd_s;

	typedef struct packed {
		logic [4:0] rsvd;
		logic       nb;
		logic       err;
		logic       end_of_transfer_ack;
	} dlt_stat_s;

	localparam dlt_cmd_s DLT_CMD_WAKE =
		'{DLT_RSVD_ZERO, 1'b0, 1'b0, DLT_OP_WAKE};
	localparam dlt_cmd_s DLT_CMD_WRITE_B =
		'{DLT_RSVD_ZERO, 1'b0, 1'b0, DLT_OP_WRITE};
	localparam dlt_cmd_s DLT_CMD_READ_B =
		'{DLT_RSVD_ZERO, 1'b0, 1'b0, DLT_OP_READ};

	// ------------------------------------------------------------
	// modes, states, carriers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DLT_MODE_NORMAL,
		DLT_MODE_SLEEP,
		DLT_MODE_STOP
	} dlt_mode_e;

	typedef enum logic [3:0] {
		LS_IDLE, LS_ADDR, LS_DLO, LS_DHI, LS_ISSUE,
		LS_WAIT, LS_STAT, LS_RLO, LS_RHI
	} dlt_link_st_e;

	typedef struct packed {
		logic                  we;
		logic                  word;
		logic                  nb;
		logic [DLT_ADDR_W-1:0] addr;
		logic [DLT_WORD_W-1:0] wdata;
	} dlt_req_s;

	typedef struct packed {
		logic                  err;
		logic [DLT_WORD_W-1:0] rdata;
	} dlt_rsp_s;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic dlt_cmd_known(input dlt_cmd_s c);
		logic ok;
		ok = (c.op == DLT_OP_WRITE) ||
			((c.op == DLT_OP_READ) && !c.nb) ||
			(c == DLT_CMD_WAKE);
		return ok && (c.rsvd == DLT_RSVD_ZERO);
	endfunction

	function automatic logic dlt_misaligned(input dlt_req_s r);
		return r.word && r.addr[DLT_ADDR_LSB];
	endfunction

endpackage

// *** hw/dlt_sync.sv ***
// two-stage synchroniser for levels and toggles
// assumes: input steady for two destination edges per change
module dlt_sync #(
	parameter int W = 1
) (
	// destination clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} dlt_sync_s;

	dlt_sync_s state_reg;
	dlt_sync_s state_next;

	always_comb begin
		state_next.s1 = i_d;
		state_next.s2 = state_reg.s1;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_q = state_reg.s2;

endmodule

// *** hw/dlt_core.sv ***
// die link target: system-clock side of the transfer handshake
// assumes: request toggle and wake toggle arrive synchronised;
// request data held stable until the answer toggle returns
module dlt_core #(
	parameter int IRQ_N = 8
) (
	// clock and reset
	input  wire logic               i_mclk,
	input  wire logic               i_rst,
	// from link side
	input  wire dlt_pkg::dlt_req_s  i_req,
	input  wire logic               i_req_tgl_s,
	input  wire logic               i_wake_tgl_s,
	output logic                    o_ack_tgl,
	output dlt_pkg::dlt_rsp_s       o_rsp,
	// power state and interrupts
	input  wire dlt_pkg::dlt_mode_e i_mode,
	input  wire logic [IRQ_N-1:0]   i_irq,
	output logic                    o_irq_line,
	output logic                    o_wake,
	// register access
	output logic                    o_reg_strobe,
	output dlt_pkg::dlt_req_s       o_reg_cmd,
	input  wire logic               i_reg_done,
	input  wire dlt_pkg::dlt_rsp_s  i_reg_rsp
);

	typedef enum logic {CS_IDLE, CS_ACC} dlt_core_st_e;

	typedef struct packed {
		dlt_core_st_e       st;
		logic               seen;
		logic               ack_tgl;
		dlt_pkg::dlt_rsp_s  rsp;
		logic               strobe;
		dlt_pkg::dlt_req_s  cmd;
		logic               irq;
		logic               wake;
		logic               wake_seen;
		logic               wake_pend;
		dlt_pkg::dlt_mode_e mode_q;
	} dlt_core_s;

	dlt_core_s core_reg;
	dlt_core_s core_next;

	always_comb begin
		core_next           = core_reg;
		core_next.strobe    = 1'b0;
		core_next.mode_q    = i_mode;
		core_next.wake_seen = i_wake_tgl_s;
		// wake command seen on the link during stop
		core_next.wake = i_wake_tgl_s != core_reg.wake_seen;
		unique case (core_reg.st)
			CS_IDLE: begin
				if (i_req_tgl_s != core_reg.seen) begin
					core_next.seen      = i_req_tgl_s;
					core_next.cmd       = i_req;
					core_next.strobe    = 1'b1;
					core_next.wake_pend = 1'b0;
					core_next.st        = CS_ACC;
				end
			end
			CS_ACC: begin
				if (i_reg_done) begin
					core_next.rsp     = i_reg_rsp;
					core_next.ack_tgl = !core_reg.ack_tgl;
					core_next.st      = CS_IDLE;
				end
			end
		endcase
		// leaving stop: raise the line until the controller talks
		if (core_reg.mode_q == dlt_pkg::DLT_MODE_STOP &&
			i_mode == dlt_pkg::DLT_MODE_NORMAL) begin
			core_next.wake_pend = 1'b1;
		end
		core_next.irq = (i_mode == dlt_pkg::DLT_MODE_NORMAL) &&
			((|i_irq) || core_next.wake_pend);
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			core_reg <= '0;
		end else begin
			core_reg <= core_next;
		end
	end

	assign o_ack_tgl    = core_reg.ack_tgl;
	assign o_rsp        = core_reg.rsp;
	assign o_irq_line   = core_reg.irq;
	assign o_wake       = core_reg.wake;
	assign o_reg_strobe = core_reg.strobe;
	assign o_reg_cmd    = core_reg.cmd;

endmodule

// *** hw/dlt_target.sv ***
// die link target: top level and link-clock transfer engine
// assumes: initiator drives the link clock and the idle bus low;
// register slaves and power controller run on i_mclk
module dlt_target #(
	parameter int IRQ_N = 8
) (
	// system clock and reset
	input  wire logic                           i_mclk,
	input  wire logic                           i_rst,
	// power state, interrupt sources, wake
	input  wire dlt_pkg::dlt_mode_e             i_mode,
	input  wire logic [IRQ_N-1:0]               i_irq,
	output logic                                o_wake,
	// link pins
	input  wire logic                           i_die_link_clock,
	input  wire logic [dlt_pkg::DLT_DATA_W-1:0] i_die_link_data,
	output logic [dlt_pkg::DLT_DATA_W-1:0]      o_die_link_data,
	output logic                                o_die_link_data_oe,
	output logic                                o_die_link_interrupt,
	// register access
	output logic                                o_reg_strobe,
	output dlt_pkg::dlt_req_s                   o_reg_cmd,
	input  wire logic                           i_reg_done,
	input  wire dlt_pkg::dlt_rsp_s              i_reg_rsp
);

	// ------------------------------------------------------------
	// types and signals
	// ------------------------------------------------------------
	localparam int MODE_W  = $bits(dlt_pkg::dlt_mode_e);
	localparam int LSYNC_W = MODE_W + 2;
	localparam int DW      = dlt_pkg::DLT_DATA_W;
	localparam int WW      = dlt_pkg::DLT_WORD_W;
	localparam dlt_pkg::dlt_link_st_e
		LS_IDLE  = dlt_pkg::LS_IDLE,  LS_ADDR = dlt_pkg::LS_ADDR,
		LS_DLO   = dlt_pkg::LS_DLO,   LS_DHI  = dlt_pkg::LS_DHI,
		LS_ISSUE = dlt_pkg::LS_ISSUE, LS_WAIT = dlt_pkg::LS_WAIT,
		LS_STAT  = dlt_pkg::LS_STAT,  LS_RLO  = dlt_pkg::LS_RLO,
		LS_RHI   = dlt_pkg::LS_RHI;

	typedef struct packed {
		dlt_pkg::dlt_link_st_e st;
		dlt_pkg::dlt_req_s     req;
		dlt_pkg::dlt_req_s     xfer;
		logic                  req_tgl;
		logic                  rd;
		logic                  err;
		dlt_pkg::dlt_rsp_s     rsp;
		logic                  wake_tgl;
		logic                  oe;
		logic [DW-1:0]         dout;
	} dlt_link_s;

	dlt_link_s             link_reg;
	dlt_link_s             link_next;
	logic                  rst_l;
	logic                  ack_tgl;
	logic                  ack_s;
	logic [MODE_W-1:0]     mode_raw;
	dlt_pkg::dlt_mode_e    mode_s;
	logic                  req_tgl_s;
	logic                  wake_tgl_s;
	dlt_pkg::dlt_rsp_s     core_rsp;
	logic                  en;
	logic                  pending;
	dlt_pkg::dlt_cmd_s     rx_cmd;
	dlt_pkg::dlt_stat_s    stat;

	// ------------------------------------------------------------
	// crossings
	// ------------------------------------------------------------
	// reset, answer toggle and power mode into the link clock
	dlt_sync #(.W(LSYNC_W)) u_link_sync (
		.i_clk (i_die_link_clock),
		.i_rst (1'b0),
		.i_d   ({i_rst, ack_tgl, i_mode}),
		.o_q   ({rst_l, ack_s, mode_raw})
	);

	// request and wake toggles into the system clock
	dlt_sync #(.W(2)) u_core_sync (
		.i_clk (i_mclk),
		.i_rst (i_rst),
		.i_d   ({link_reg.req_tgl, link_reg.wake_tgl}),
		.o_q   ({req_tgl_s, wake_tgl_s})
	);

	// ------------------------------------------------------------
	// system-clock side
	// ------------------------------------------------------------
	dlt_core #(.IRQ_N(IRQ_N)) u_core (
		.i_mclk       (i_mclk),
		.i_rst        (i_rst),
		.i_req        (link_reg.xfer),
		.i_req_tgl_s  (req_tgl_s),
		.i_wake_tgl_s (wake_tgl_s),
		.o_ack_tgl    (ack_tgl),
		.o_rsp        (core_rsp),
		.i_mode       (i_mode),
		.i_irq        (i_irq),
		.o_irq_line   (o_die_link_interrupt),
		.o_wake       (o_wake),
		.o_reg_strobe (o_reg_strobe),
		.o_reg_cmd    (o_reg_cmd),
		.i_reg_done   (i_reg_done),
		.i_reg_rsp    (i_reg_rsp)
	);

	// ------------------------------------------------------------
	// link engine
	// ------------------------------------------------------------
	assign mode_s  = dlt_pkg::dlt_mode_e'(mode_raw);
	assign en      = mode_s == dlt_pkg::DLT_MODE_NORMAL;
	assign pending = link_reg.req_tgl != ack_s;
	assign rx_cmd  = dlt_pkg::dlt_cmd_s'(i_die_link_data);

	always_comb begin
		link_next = link_reg;
		stat      = '0;
		unique case (link_reg.st)
			LS_IDLE: begin
				link_next.err    = 1'b0;
				link_next.rd     = 1'b0;
				link_next.req.nb = 1'b0;
				// in normal mode any non-idle byte is decoded; only a known read or write command starts a transfer
				if (i_die_link_data != dlt_pkg::DLT_IDLE_BYTE) begin
					if (!en) begin
						if (mode_s == dlt_pkg::DLT_MODE_STOP &&
							rx_cmd == dlt_pkg::DLT_CMD_WAKE) begin
							link_next.wake_tgl = !link_reg.wake_tgl;
						end
					end else if (!dlt_pkg::dlt_cmd_known(rx_cmd)) begin
						link_next.err = 1'b1;
						link_next.st  = LS_STAT;
					end else if (rx_cmd.op == dlt_pkg::DLT_OP_WAKE) begin
						link_next.st  = LS_STAT;
					end else begin
						link_next.req.we   = rx_cmd.op == dlt_pkg::DLT_OP_WRITE;
						link_next.rd       = rx_cmd.op == dlt_pkg::DLT_OP_READ;
						link_next.req.word = rx_cmd.word;
						link_next.req.nb   = rx_cmd.nb;
						link_next.st       = LS_ADDR;
					end
				end
			end
			LS_ADDR: begin
				link_next.req.addr = i_die_link_data;
				link_next.st = link_reg.req.we ? LS_DLO : LS_ISSUE;
			end
			LS_DLO: begin
				link_next.req.wdata[DW-1:0] = i_die_link_data;
				link_next.st = link_reg.req.word ? LS_DHI : LS_ISSUE;
			end
			LS_DHI: begin
				link_next.req.wdata[WW-1:DW] = i_die_link_data;
				link_next.st = LS_ISSUE;
			end
			LS_ISSUE: begin
				// previous non-blocking write must be finished first
				if (!pending) begin
					if (dlt_pkg::dlt_misaligned(link_reg.req)) begin
						link_next.err = 1'b1;
						link_next.st  = LS_STAT;
					end else begin
						link_next.xfer    = link_reg.req;
						link_next.req_tgl = !link_reg.req_tgl;
						// non-blocking write answers at once
						link_next.st = link_reg.req.nb ? LS_STAT : LS_WAIT;
					end
				end
			end
			LS_WAIT: begin
				if (!pending) begin
					link_next.rsp = core_rsp;
					link_next.err = core_rsp.err;
					link_next.st  = LS_STAT;
				end
			end
			LS_STAT: begin
				link_next.st = (link_reg.rd && !link_reg.err) ? LS_RLO : LS_IDLE;
			end
			LS_RLO: link_next.st = link_reg.req.word ? LS_RHI : LS_IDLE;
			LS_RHI: link_next.st = LS_IDLE;
			default: link_next.st = LS_IDLE;
		endcase
		// sleep and stop abandon any transfer
		if (!en) begin
			link_next.st = LS_IDLE;
		end
		stat.end_of_transfer_ack = 1'b1;
		stat.err = link_next.err;
		stat.nb  = link_next.req.nb && link_next.req.we;
		link_next.oe   = 1'b1;
		link_next.dout = dlt_pkg::DLT_IDLE_BYTE;
		unique case (link_next.st)
			LS_ISSUE, LS_WAIT: begin
				link_next.dout = dlt_pkg::DLT_IDLE_BYTE;
			end
			LS_STAT: begin
				link_next.dout = stat;
			end
			LS_RLO: begin
				link_next.dout = link_next.rsp.rdata[DW-1:0];
			end
			LS_RHI: begin
				link_next.dout = link_next.rsp.rdata[WW-1:DW];
			end
			LS_IDLE, LS_ADDR, LS_DLO, LS_DHI: begin
				link_next.oe = 1'b0;
			end
			default: link_next.oe = 1'b0;
		endcase
	end

	always_ff @(posedge i_die_link_clock) begin
		if (rst_l) begin
			link_reg <= '0;
		end else begin
			link_reg <= link_next;
		end
	end

	// ------------------------------------------------------------
	// pins
	// ------------------------------------------------------------
	// gated by the system-side mode as the link clock may be stopped
	assign o_die_link_data_oe = link_reg.oe &&
		(i_mode == dlt_pkg::DLT_MODE_NORMAL);
	assign o_die_link_data = o_die_link_data_oe ?
		link_reg.dout : dlt_pkg::DLT_IDLE_BYTE;

	// ------------------------------------------------------------
	// checks on the link clock
	// ------------------------------------------------------------
	sequence s_bad_cmd;
		link_reg.st == LS_IDLE && en &&
		i_die_link_data != dlt_pkg::DLT_IDLE_BYTE &&
		!dlt_pkg::dlt_cmd_known(rx_cmd);
	endsequence

	sequence s_wr_start;
		(link_reg.st == LS_IDLE && en &&
		rx_cmd == dlt_pkg::DLT_CMD_WRITE_B) ##1
		(link_reg.st == LS_ADDR && en);
	endsequence

	sequence s_rd_start;
		(link_reg.st == LS_IDLE && en &&
		rx_cmd == dlt_pkg::DLT_CMD_READ_B) ##1
		(link_reg.st == LS_ADDR && en);
	endsequence

	property p_disabled_quiet;
		@(posedge i_die_link_clock) disable iff (rst_l)
		!en |=> !link_reg.oe && link_reg.st == LS_IDLE;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("link drives while disabled");

	property p_status_eot;
		@(posedge i_die_link_clock) disable iff (rst_l)
		link_reg.st == LS_STAT |->
			link_reg.oe && link_reg.dout[0] == 1'b1;
	endproperty
	a_status_eot: assert property (p_status_eot)
		else $error("status byte without end acknowledge");

	property p_bad_cmd;
		@(posedge i_die_link_clock) disable iff (rst_l)
		s_bad_cmd |=> (link_reg.st == LS_STAT && link_reg.err &&
			$stable(link_reg.req_tgl)) ##1 link_reg.st == LS_IDLE;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd)
		else $error("unknown command not abandoned with error");

	property p_write_seq;
		@(posedge i_die_link_clock) disable iff (rst_l)
		s_wr_start |=> link_reg.st == LS_DLO;
	endproperty
	a_write_seq: assert property (p_write_seq)
		else $error("write did not move to data phase");

	property p_read_seq;
		@(posedge i_die_link_clock) disable iff (rst_l)
		s_rd_start |=> link_reg.st == LS_ISSUE && link_reg.oe;
	endproperty
	a_read_seq: assert property (p_read_seq)
		else $error("read did not issue after address");

	property p_read_data;
		@(posedge i_die_link_clock) disable iff (rst_l)
		(link_reg.st == LS_STAT && link_reg.rd && !link_reg.err && en)
		|=> link_reg.st == LS_RLO &&
			link_reg.dout == link_reg.rsp.rdata[DW-1:0];
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("read data not returned after status");

	property p_nb_no_wait;
		@(posedge i_die_link_clock) disable iff (rst_l)
		(link_reg.st == LS_ISSUE && en && !pending && link_reg.req.nb &&
		!dlt_pkg::dlt_misaligned(link_reg.req)) |=>
			link_reg.st == LS_STAT && $changed(link_reg.req_tgl);
	endproperty
	a_nb_no_wait: assert property (p_nb_no_wait)
		else $error("non-blocking write waited");

	property p_blocking_waits;
		@(posedge i_die_link_clock) disable iff (rst_l)
		(link_reg.st == LS_WAIT && en && pending) |=>
			link_reg.st == LS_WAIT && link_reg.dout == '0;
	endproperty
	a_blocking_waits: assert property (p_blocking_waits)
		else $error("blocking transfer ended before answer");

	property p_misaligned;
		@(posedge i_die_link_clock) disable iff (rst_l)
		(link_reg.st == LS_ISSUE && en && !pending &&
		dlt_pkg::dlt_misaligned(link_reg.req)) |=>
			link_reg.err && $stable(link_reg.req_tgl);
	endproperty
	a_misaligned: assert property (p_misaligned)
		else $error("odd word address reached the registers");

	property p_wake_cmd;
		@(posedge i_die_link_clock) disable iff (rst_l)
		(link_reg.st == LS_IDLE && mode_s == dlt_pkg::DLT_MODE_STOP &&
		rx_cmd == dlt_pkg::DLT_CMD_WAKE) |=> $changed(link_reg.wake_tgl);
	endproperty
	a_wake_cmd: assert property (p_wake_cmd)
		else $error("wake command in stop not recognised");

	// ------------------------------------------------------------
	// checks on the system clock
	// ------------------------------------------------------------
	sequence s_stop_exit;
		i_mode == dlt_pkg::DLT_MODE_STOP ##1
		i_mode == dlt_pkg::DLT_MODE_NORMAL;
	endsequence

	property p_irq_merge;
		@(posedge i_mclk) disable iff (i_rst)
		(i_mode == dlt_pkg::DLT_MODE_NORMAL && |i_irq) |=>
			o_die_link_interrupt;
	endproperty
	a_irq_merge: assert property (p_irq_merge)
		else $error("interrupt request not on the line");

	property p_irq_off;
		@(posedge i_mclk) disable iff (i_rst)
		i_mode != dlt_pkg::DLT_MODE_NORMAL |=> !o_die_link_interrupt;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt line active while disabled");

	property p_stop_wake;
		@(posedge i_mclk) disable iff (i_rst)
		s_stop_exit |=> o_die_link_interrupt;
	endproperty
	a_stop_wake: assert property (p_stop_wake)
		else $error("no wake interrupt after leaving stop");

endmodule

// *** dv/dlt_init_model.sv ***
// initiator model for the die link: clock runs only while a task ticks it
// assumes: bench resolves the wire, pull-down when nobody drives
module dlt_init_model (
	// link side
	output logic            o_clk,
	output logic [7:0]      o_data,
	output logic            o_oe,
	input  wire logic [7:0] i_line,
	input  wire logic       i_t_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] BLK_PAGE = 8'h02;
	logic [7:0] smp;
	logic       soe;
	initial begin
		o_clk = 1'b0;
		o_data = 8'h00;
		o_oe = 1'b0;
	end
	// one link cycle, sampled just before the rising edge
	task automatic tick();
		#16;
		smp = i_line;
		soe = i_t_oe;
		o_clk = 1'b1;
		#16;
		o_clk = 1'b0;
	endtask
	task automatic clocks(input int n);
		repeat (n) tick();
	endtask
	task automatic put(input logic [7:0] b);
		o_oe = 1'b1;
		o_data = b;
		tick();
	endtask
	// release, wait for status, then collect read bytes
	task automatic finish(input int nrd, output logic [7:0] st,
		output logic [15:0] rd, output logic ok);
		ok = 1'b0;
		st = 8'h00;
		rd = 16'h0000;
		o_oe = 1'b0;
		for (int i = 0; i < 64 && !ok; i++) begin
			tick();
			ok = soe && (smp != 8'h00);
			st = smp;
		end
		for (int j = 0; j < nrd && ok; j++) begin
			tick();
			rd[8*j +: 8] = smp;
		end
		if (ok) clocks(2);
	endtask
	// global address picks blocking or posted window
	task automatic access(input logic [15:0] ga, input logic we, word,
		input logic [15:0] wd, output logic [7:0] st,
		output logic [15:0] rd, output logic ok);
		logic nb;
		nb = ga[15:8] != BLK_PAGE;
		put({2'b00, word, nb, we ? 4'h1 : 4'h2});
		put(ga[7:0]);
		if (we) put(wd[7:0]);
		if (we && word) put(wd[15:8]);
		finish(we ? 0 : (word ? 2 : 1), st, rd, ok);
	endtask
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the die link target
// assumes: initiator model beside it, register slave modelled here
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int IRQ_N = 8;
	logic               i_mclk;
	logic               i_rst;
	dlt_pkg::dlt_mode_e i_mode;
	logic [IRQ_N-1:0]   i_irq;
	logic               o_wake;
	logic               o_reg_strobe;
	logic               i_reg_done;
	logic               dout_oe;
	logic               intr;
	logic               lclk;
	logic               ioe;
	logic [7:0]         dout;
	logic [7:0]         idat;
	logic [7:0]         line;
	logic [7:0]         st;
	logic [15:0]        rd;
	logic               ok;
	dlt_pkg::dlt_req_s  o_reg_cmd;
	dlt_pkg::dlt_rsp_s  i_reg_rsp;
	dlt_pkg::dlt_req_s  e;
	dlt_pkg::dlt_req_s  exp_q[$];
	logic [7:0]         bad_cmd[3] = '{8'h03, 8'h81, 8'h12};
	int                 num_errors = 0;
	int                 checks_done = 0;
	int                 wake_cnt = 0;

	// pull-down when released
	assign line = dout_oe ? dout : (ioe ? idat : 8'h00);

	dlt_target #(.IRQ_N(IRQ_N)) DUT (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_mode(i_mode), .i_irq(i_irq),
		.o_wake(o_wake), .i_die_link_clock(lclk), .i_die_link_data(line),
		.o_die_link_data(dout), .o_die_link_data_oe(dout_oe),
		.o_die_link_interrupt(intr), .o_reg_strobe(o_reg_strobe),
		.o_reg_cmd(o_reg_cmd), .i_reg_done(i_reg_done),
		.i_reg_rsp(i_reg_rsp)
	);
	dlt_init_model u_init (
		.o_clk(lclk), .o_data(idat), .o_oe(ioe), .i_line(line),
		.i_t_oe(dout_oe)
	);

	// ------------------------------------------------------------
	// clock, helpers, register slave, result watcher
	// ------------------------------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		dlt_pkg::dlt_req_s c;
		i_reg_done = 1'b0;
		i_reg_rsp = '0;
		forever begin
			@(posedge i_mclk);
			if (o_reg_strobe === 1'b1) begin
				c = o_reg_cmd;
				repeat ($urandom_range(4, 1)) @(posedge i_mclk);
				#1;
				i_reg_done = 1'b1;
				i_reg_rsp = {c.addr == 8'hEE, ~c.addr, c.addr};
				@(posedge i_mclk);
				#1;
				i_reg_done = 1'b0;
			end
		end
	end
	always @(posedge i_mclk) begin
		if (o_wake === 1'b1) wake_cnt++;
		if (!i_rst && o_reg_strobe === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("stray strobe", 1, 0);
			end else begin
				e = exp_q.pop_front();
				check("cmd", {o_reg_cmd.we, o_reg_cmd.word, o_reg_cmd.nb,
					o_reg_cmd.addr}, {e.we, e.word, e.nb, e.addr});
				if (e.we) check("wlo", o_reg_cmd.wdata[7:0], e.wdata[7:0]);
				if (e.we && e.word) check("whi", o_reg_cmd.wdata[15:8],
					e.wdata[15:8]);
			end
		end
	end
	task automatic xfer(input logic [15:0] ga, input logic we, word,
		input logic [7:0] exp_st);
		logic [15:0] wd;
		wd = 16'($urandom);
		exp_q.push_back('{we, word, ga[15:8] == 8'h03, ga[7:0], wd});
		u_init.access(ga, we, word, wd, st, rd, ok);
		check("answered", ok, 1);
		check("status", st, exp_st);
		if (!we) check("rdata", rd,
			word ? {~ga[7:0], ga[7:0]} : {8'h00, ga[7:0]});
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] a;
		void'($urandom(20));
		i_rst = 1'b1;
		i_mode = dlt_pkg::DLT_MODE_NORMAL;
		i_irq = '0;
		fork
			u_init.clocks(5);
			step(6);
		join
		check("reset pins", {o_reg_strobe, o_wake, intr, dout_oe, dout},
			0);
		step(1);
		i_rst = 1'b0;
		u_init.clocks(6);
		$display("test reset done");
		for (int k = 0; k < 15; k++) begin
			a = 8'($urandom_range(118, 0)) << 1;
			case (k % 5)
				0: xfer({8'h02, a}, 1'b1, 1'b0, 8'h01);
				1: xfer({8'h02, a}, 1'b1, 1'b1, 8'h01);
				2: xfer({8'h02, a}, 1'b0, 1'b0, 8'h01);
				3: xfer({8'h02, a}, 1'b0, 1'b1, 8'h01);
				default: xfer({8'h03, a}, 1'b1, k[0], 8'h05);
			endcase
		end
		xfer(16'h02EE, 1'b1, 1'b0, 8'h03);
		$display("test transfers done");
		foreach (bad_cmd[i]) begin
			u_init.put(bad_cmd[i]);
			u_init.finish(0, st, rd, ok);
			check("bad cmd", {ok, st[1]}, 2'b11);
		end
		u_init.put(8'h22);
		u_init.put(8'h11);
		u_init.finish(0, st, rd, ok);
		check("odd word", {ok, st[1]}, 2'b11);
		u_init.put(8'h05);
		u_init.finish(0, st, rd, ok);
		check("wake normal", {ok, st}, 9'h101);
		$display("test refusals done");
		step(1);
		for (int i = 0; i < IRQ_N; i++) begin
			i_irq = '0;
			i_irq[i] = 1'b1;
			step(2);
			check("irq merged", intr, 1);
			i_irq = '0;
			step(2);
			check("irq idle", intr, 0);
		end
		$display("test interrupt done");
		step(1);
		i_mode = dlt_pkg::DLT_MODE_SLEEP;
		i_irq = '1;
		step(2);
		check("sleep pins", {dout_oe, dout, intr}, 0);
		u_init.put(8'h01);
		u_init.put(8'h10);
		u_init.put(8'h5A);
		u_init.finish(0, st, rd, ok);
		check("sleep quiet", {ok, dout_oe, dout}, 0);
		step(1);
		i_mode = dlt_pkg::DLT_MODE_NORMAL;
		i_irq = '0;
		u_init.clocks(4);
		$display("test sleep done");
		check("no wake", wake_cnt, 0);
		step(1);
		i_mode = dlt_pkg::DLT_MODE_STOP;
		u_init.clocks(4);
		u_init.put(8'h05);
		u_init.finish(0, st, rd, ok);
		check("stop wake", {ok, 8'(wake_cnt)}, 9'h001);
		step(1);
		i_mode = dlt_pkg::DLT_MODE_NORMAL;
		step(3);
		check("wake irq", intr, 1);
		u_init.clocks(4);
		xfer(16'h0240, 1'b1, 1'b0, 8'h01);
		step(2);
		check("wake irq clr", intr, 0);
		check("queue drained", exp_q.size(), 0);
		$display("test stop done");
		complete_run();
	end
	initial begin
		#300us;
		num_errors++;
		complete_run();
	end
endmodule
